/* File: mbm_fifo_model.sv */
// Model of the two FIFO memories at the far side of the bus matching block
`timescale 1ns/1ps
module mbm_fifo_model (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_stall,
	input  wire logic        i_pop,
	input  wire logic        i_push,
	input  wire logic [35:0] i_push_word,
	output logic      [35:0] o_fifo1_word,
	output logic             o_fifo1_valid,
	output logic      [35:0] o_fifo2_out_word,
	output logic             o_room,
	output int               o_pop_cnt,
	output int               o_push_cnt
);
	// Next FIFO1 long word follows the pop count
	assign o_fifo1_word  = 36'h1_2345_6789 + 36'(o_pop_cnt) * 36'h1_1111_1111;
	assign o_fifo1_valid = !i_stall;
	assign o_room        = !i_stall;
	// Only whole long words enter FIFO2
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_pop_cnt        <= 0;
			o_push_cnt       <= 0;
			o_fifo2_out_word <= 36'h0_0000_0000;
		end else begin
			if (i_pop)
				o_pop_cnt <= o_pop_cnt + 1;
			if (i_push) begin
				o_push_cnt       <= o_push_cnt + 1;
				o_fifo2_out_word <= i_push_word;
			end
		end
	end
endmodule : mbm_fifo_model

/* File: mbm_mailbox.sv */
// One mailbox register with its vacancy flag
`timescale 1ns/1ps
module mbm_mailbox #(
	parameter int W = 36
) (
	input  wire logic         i_clk,
	input  wire logic         i_nrst,
	input  wire logic         i_clear,
	input  wire logic         i_write,
	input  wire logic         i_read,
	input  wire logic [W-1:0] i_data,
	input  wire logic [W-1:0] i_mask,
	output logic      [W-1:0] o_data,
	output logic              o_vacant
);

	logic [W-1:0] data;
	logic         vacant;
	logic [W-1:0] next_data;
	logic         next_vacant;
	logic         accept;

	always_comb begin
		accept      = i_write && vacant && !i_clear;
		next_data   = data;
		next_vacant = vacant;
		if (i_clear) begin
			next_vacant = 1'b1;
		end else begin
			if (i_read) begin
				next_vacant = 1'b1;
			end
			if (accept) begin
				next_data   = i_data & i_mask;
				next_vacant = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			data   <= '0;
			vacant <= 1'b1;
		end else begin
			data   <= next_data;
			vacant <= next_vacant;
		end
	end

	assign o_data   = data;
	assign o_vacant = vacant;

	a_full_blocks_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(!vacant && !i_read && !i_clear) |=> ($stable(data) && !vacant))
		else $error("write into unread mailbox changed it");

	a_write_stores: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(i_write && vacant && !i_clear) |=> (!vacant && data == $past(i_data & i_mask)))
		else $error("accepted mail write not stored");

endmodule : mbm_mailbox

/* File: mbm_piece_sel.sv */
// Picks one port B piece of a long word by index, width and byte order
`timescale 1ns/1ps
module mbm_piece_sel (
	input  wire logic [35:0]         i_word,
	input  wire logic [1:0]          i_idx,
	input  wire mbm_pkg::mbm_cfg_s   i_cfg,
	output logic      [35:0]         o_piece
);

	logic [1:0] pos;

	always_comb begin
		pos     = i_cfg.big_endian ? (mbm_pkg::last_idx(i_cfg.width) - i_idx) : i_idx;
		o_piece = i_word;
		case (i_cfg.width)
			mbm_pkg::MBM_W18: o_piece = (i_word >> (pos * mbm_pkg::SHIFT_18)) & mbm_pkg::LANES_18;
			mbm_pkg::MBM_W9:  o_piece = (i_word >> (pos * mbm_pkg::SHIFT_9)) & mbm_pkg::LANES_9;
			default:          o_piece = i_word;
		endcase
	end

endmodule : mbm_piece_sel

/* File: mbm_pkg.sv */
// Shared types and constants for the mailbox and port B bus matching block
package mbm_pkg;

	typedef enum logic [1:0] {
		MBM_W36,
		MBM_W18,
		MBM_W9
	} mbm_width_e;

	typedef struct packed {
		mbm_width_e width;
		logic       big_endian;
	} mbm_cfg_s;

	typedef struct packed {
		logic chip_sel_n;
		logic direction;
		logic xfer_gate;
		logic mail_select;
	} mbm_port_s;

	localparam int          DATA_W      = 36;
	localparam logic [35:0] LANES_36    = 36'hF_FFFF_FFFF;
	localparam logic [35:0] LANES_18    = 36'h0_0003_FFFF;
	localparam logic [35:0] LANES_9     = 36'h0_0000_01FF;
	localparam logic [1:0]  LAST_IDX_36 = 2'h0;
	localparam logic [1:0]  LAST_IDX_18 = 2'h1;
	localparam logic [1:0]  LAST_IDX_9  = 2'h3;
	localparam logic [5:0]  SHIFT_18    = 6'h12;
	localparam logic [5:0]  SHIFT_9     = 6'h09;
	localparam mbm_cfg_s    CFG_RESET   = '{width: MBM_W36, big_endian: 1'b1};

	function automatic logic [35:0] lane_mask(input mbm_width_e w);
		case (w)
			MBM_W18: lane_mask = LANES_18;
			MBM_W9:  lane_mask = LANES_9;
			default: lane_mask = LANES_36;
		endcase
	endfunction : lane_mask

	function automatic logic [1:0] last_idx(input mbm_width_e w);
		case (w)
			MBM_W18: last_idx = LAST_IDX_18;
			MBM_W9:  last_idx = LAST_IDX_9;
			default: last_idx = LAST_IDX_36;
		endcase
	endfunction : last_idx

endpackage : mbm_pkg

/* File: mbm_top.sv */
// Mailboxes and port B bus matching between two ports and the FIFO memories
`timescale 1ns/1ps
module mbm_top (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_first_full_reset_n,
	input  wire logic        i_second_full_reset_n,
	input  wire logic        i_width_match_select,
	input  wire logic        i_narrow_width_select,
	input  wire logic        i_endian_order_select,
	input  wire logic        i_port_a_chip_sel_n,
	input  wire logic        i_port_a_direction,
	input  wire logic        i_port_a_xfer_gate,
	input  wire logic        i_port_a_mail_select,
	input  wire logic [35:0] i_a_data,
	output logic      [35:0] o_a_data,
	output logic             o_a_data_oe,
	input  wire logic        i_port_b_chip_sel_n,
	input  wire logic        i_port_b_direction,
	input  wire logic        i_port_b_xfer_gate,
	input  wire logic        i_port_b_mail_select,
	input  wire logic [35:0] i_b_data,
	output logic      [35:0] o_b_data,
	output logic             o_b_data_oe,
	input  wire logic [35:0] i_fifo2_out_word,
	input  wire logic [35:0] i_fifo1_word,
	input  wire logic        i_fifo1_valid,
	output logic             o_fifo1_pop,
	input  wire logic        i_port_b_room_flag,
	output logic      [35:0] o_fifo2_word,
	output logic             o_fifo2_push,
	output logic             o_mail_to_b_vacant,
	output logic             o_mail_to_a_vacant,
	output logic      [1:0]  o_port_b_width,
	output logic             o_big_endian
);

	mbm_pkg::mbm_port_s pa;
	mbm_pkg::mbm_port_s pb;
	mbm_pkg::mbm_cfg_s  cfg;
	mbm_pkg::mbm_cfg_s  next_cfg;
	mbm_pkg::mbm_width_e sel_width;
	logic               mrs_prev;
	logic               next_mrs_prev;
	logic               mrs_done;
	logic               mrs_rise;
	logic [35:0]        mask;
	logic [1:0]         last;

	logic               a_write;
	logic               a_read;
	logic               b_write;
	logic               b_read;
	logic               a_mail_wr;
	logic               a_mail_rd;
	logic               b_mail_wr;
	logic               b_mail_rd;
	logic [35:0]        mail_ab;
	logic [35:0]        mail_ba;

	logic [35:0]        out_reg;
	logic [35:0]        hold;
	logic [1:0]         rd_idx;
	logic [35:0]        next_out_reg;
	logic [35:0]        next_hold;
	logic [1:0]         next_rd_idx;
	logic               fifo_rd;
	logic               fetch;
	logic [35:0]        piece_src;
	logic [35:0]        piece;

	logic [35:0]        asm_word;
	logic [1:0]         wr_idx;
	logic [35:0]        f2_word;
	logic               push;
	logic [35:0]        next_asm_word;
	logic [1:0]         next_wr_idx;
	logic [35:0]        next_f2_word;
	logic               next_push;
	logic               fifo_wr;
	logic [1:0]         wr_pos;
	logic [5:0]         wr_shift;
	logic [35:0]        placed;

	assign pa = '{chip_sel_n: i_port_a_chip_sel_n, direction: i_port_a_direction,
	              xfer_gate: i_port_a_xfer_gate, mail_select: i_port_a_mail_select};
	assign pb = '{chip_sel_n: i_port_b_chip_sel_n, direction: i_port_b_direction,
	              xfer_gate: i_port_b_xfer_gate, mail_select: i_port_b_mail_select};

	// Configuration latch at master reset release
	assign mrs_done = i_first_full_reset_n && i_second_full_reset_n;
	assign mrs_rise = mrs_done && !mrs_prev;

	always_comb begin
		if (!i_width_match_select) begin
			sel_width = mbm_pkg::MBM_W36;
		end else if (!i_narrow_width_select) begin
			sel_width = mbm_pkg::MBM_W18;
		end else begin
			sel_width = mbm_pkg::MBM_W9;
		end
		next_mrs_prev = mrs_done;
		next_cfg      = cfg;
		if (mrs_rise) begin
			next_cfg.width      = sel_width;
			next_cfg.big_endian = i_endian_order_select;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cfg      <= mbm_pkg::CFG_RESET;
			mrs_prev <= 1'b0;
		end else begin
			cfg      <= next_cfg;
			mrs_prev <= next_mrs_prev;
		end
	end

	assign mask           = mbm_pkg::lane_mask(cfg.width);
	assign last           = mbm_pkg::last_idx(cfg.width);
	assign o_port_b_width = cfg.width;
	assign o_big_endian   = cfg.big_endian;

	// Port access decode; port A writes with direction high, port B with direction low
	assign a_write   = !pa.chip_sel_n && pa.direction && pa.xfer_gate;
	assign a_read    = !pa.chip_sel_n && !pa.direction && pa.xfer_gate;
	assign b_write   = !pb.chip_sel_n && !pb.direction && pb.xfer_gate;
	assign b_read    = !pb.chip_sel_n && pb.direction && pb.xfer_gate;
	assign a_mail_wr = a_write && pa.mail_select;
	assign a_mail_rd = a_read && pa.mail_select;
	assign b_mail_wr = b_write && pb.mail_select;
	assign b_mail_rd = b_read && pb.mail_select;

	mbm_mailbox #(
		.W(mbm_pkg::DATA_W)
	) u_mail_a_to_b (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_clear (!i_first_full_reset_n),
		.i_write (a_mail_wr),
		.i_read  (b_mail_rd),
		.i_data  (i_a_data),
		.i_mask  (mask),
		.o_data  (mail_ab),
		.o_vacant(o_mail_to_b_vacant)
	);

	mbm_mailbox #(
		.W(mbm_pkg::DATA_W)
	) u_mail_b_to_a (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_clear (!i_second_full_reset_n),
		.i_write (b_mail_wr),
		.i_read  (a_mail_rd),
		.i_data  (i_b_data),
		.i_mask  (mask),
		.o_data  (mail_ba),
		.o_vacant(o_mail_to_a_vacant)
	);

	// Output drive; mailbox words bypass the piece logic
	assign o_a_data_oe = !pa.chip_sel_n && !pa.direction;
	assign o_b_data_oe = !pb.chip_sel_n && pb.direction;
	assign o_a_data    = pa.mail_select ? (mail_ba & mask) : i_fifo2_out_word;
	assign o_b_data    = pb.mail_select ? (mail_ab & mask) : out_reg;

	// FIFO1 unpacking into the port B output register
	assign fifo_rd     = b_read && !pb.mail_select && mrs_done;
	assign fetch       = fifo_rd && (rd_idx == 2'h0) && i_fifo1_valid;
	assign o_fifo1_pop = fetch;
	assign piece_src   = (rd_idx == 2'h0) ? i_fifo1_word : hold;

	mbm_piece_sel u_rd_piece (
		.i_word (piece_src),
		.i_idx  (rd_idx),
		.i_cfg  (cfg),
		.o_piece(piece)
	);

	always_comb begin
		next_out_reg = out_reg;
		next_hold    = hold;
		next_rd_idx  = rd_idx;
		if (!mrs_done) begin
			next_rd_idx = 2'h0;
		end else if (fetch || (fifo_rd && rd_idx != 2'h0)) begin
			next_out_reg = piece;
			if (fetch) begin
				next_hold = i_fifo1_word;
			end
			next_rd_idx = (rd_idx == last) ? 2'h0 : rd_idx + 2'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			out_reg <= '0;
			hold    <= '0;
			rd_idx  <= 2'h0;
		end else begin
			out_reg <= next_out_reg;
			hold    <= next_hold;
			rd_idx  <= next_rd_idx;
		end
	end

	// FIFO2 packing from port B pieces
	assign fifo_wr = b_write && !pb.mail_select && i_port_b_room_flag && mrs_done;

	always_comb begin
		wr_pos   = cfg.big_endian ? (last - wr_idx) : wr_idx;
		wr_shift = 6'h00;
		case (cfg.width)
			mbm_pkg::MBM_W18: wr_shift = wr_pos[0] ? mbm_pkg::SHIFT_18 : 6'h00;
			mbm_pkg::MBM_W9:  wr_shift = 6'(wr_pos * mbm_pkg::SHIFT_9);
			default:          wr_shift = 6'h00;
		endcase
		placed        = (asm_word & ~(mask << wr_shift)) | ((i_b_data & mask) << wr_shift);
		next_asm_word = asm_word;
		next_wr_idx   = wr_idx;
		next_f2_word  = f2_word;
		next_push     = 1'b0;
		if (!mrs_done) begin
			next_wr_idx = 2'h0;
		end else if (fifo_wr) begin
			next_asm_word = placed;
			if (wr_idx == last) begin
				next_f2_word = placed;
				next_push    = 1'b1;
				next_wr_idx  = 2'h0;
			end else begin
				next_wr_idx = wr_idx + 2'h1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			asm_word <= '0;
			wr_idx   <= 2'h0;
			f2_word  <= '0;
			push     <= 1'b0;
		end else begin
			asm_word <= next_asm_word;
			wr_idx   <= next_wr_idx;
			f2_word  <= next_f2_word;
			push     <= next_push;
		end
	end

	assign o_fifo2_word = f2_word;
	assign o_fifo2_push = push;

	a_cfg_latch: assert property (@(posedge i_clk) disable iff (!i_nrst)
		mrs_rise |=> (cfg.big_endian == $past(i_endian_order_select) && cfg.width == $past(sel_width)))
		else $error("configuration not latched at master reset release");

	a_cfg_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(mrs_done && mrs_prev) |=> $stable(cfg))
		else $error("configuration changed outside master reset");

	a_width_decode: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(mrs_rise && !i_width_match_select) |=> cfg.width == mbm_pkg::MBM_W36)
		else $error("width match low did not select long word");

	a_mail_lanes: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(pb.mail_select && o_b_data_oe) |-> ((o_b_data & ~mask) == 36'h0_0000_0000))
		else $error("mailbox drove lanes beyond port B width");

	a_b_read_frees: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(b_mail_rd && !a_mail_wr && i_first_full_reset_n) |=> o_mail_to_b_vacant)
		else $error("port B mailbox read left flag low");

	a_long_pass: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(fetch && cfg.width == mbm_pkg::MBM_W36) |=> (out_reg == $past(i_fifo1_word) && rd_idx == 2'h0))
		else $error("long word read did not load whole word");

	a_word_push: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(cfg.width == mbm_pkg::MBM_W18 && fifo_wr && wr_idx == 2'h1)
		|=> (o_fifo2_push && o_fifo2_word == $past(placed)))
		else $error("second word did not push long word");

	a_no_early_push: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(fifo_wr && wr_idx != last) |=> !o_fifo2_push)
		else $error("partial long word pushed");

	a_single_pop: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(fetch && cfg.width == mbm_pkg::MBM_W9) |=> !o_fifo1_pop [*3])
		else $error("byte read popped memory before long word used up");

endmodule : mbm_top

/* File: mbm_top_bench.sv */
// Self-checking bench for the mailbox and port B bus matching block
`timescale 1ns/1ps
module mbm_top_bench;
	logic        i_clk, i_nrst, i_first_full_reset_n, i_second_full_reset_n;
	logic        i_width_match_select, i_narrow_width_select, i_endian_order_select;
	logic        i_port_a_chip_sel_n, i_port_a_direction, i_port_a_xfer_gate, i_port_a_mail_select;
	logic        i_port_b_chip_sel_n, i_port_b_direction, i_port_b_xfer_gate, i_port_b_mail_select;
	logic [35:0] i_a_data, o_a_data, i_b_data, o_b_data, i_fifo2_out_word, i_fifo1_word, o_fifo2_word;
	logic        o_a_data_oe, o_b_data_oe, i_fifo1_valid, o_fifo1_pop, i_port_b_room_flag, o_fifo2_push;
	logic        o_mail_to_b_vacant, o_mail_to_a_vacant, o_big_endian, stall;
	logic [1:0]  o_port_b_width;
	int          error_cnt, tests_run, cycles, pop_cnt, push_cnt;

	mbm_top dut_u (.i_clk, .i_nrst, .i_first_full_reset_n, .i_second_full_reset_n, .i_width_match_select,
		.i_narrow_width_select, .i_endian_order_select, .i_port_a_chip_sel_n, .i_port_a_direction,
		.i_port_a_xfer_gate, .i_port_a_mail_select, .i_a_data, .o_a_data, .o_a_data_oe, .i_port_b_chip_sel_n,
		.i_port_b_direction, .i_port_b_xfer_gate, .i_port_b_mail_select, .i_b_data, .o_b_data, .o_b_data_oe,
		.i_fifo2_out_word, .i_fifo1_word, .i_fifo1_valid, .o_fifo1_pop, .i_port_b_room_flag, .o_fifo2_word,
		.o_fifo2_push, .o_mail_to_b_vacant, .o_mail_to_a_vacant, .o_port_b_width, .o_big_endian);

	mbm_fifo_model far_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_stall(stall), .i_pop(o_fifo1_pop),
		.i_push(o_fifo2_push), .i_push_word(o_fifo2_word), .o_fifo1_word(i_fifo1_word),
		.o_fifo1_valid(i_fifo1_valid), .o_fifo2_out_word(i_fifo2_out_word), .o_room(i_port_b_room_flag),
		.o_pop_cnt(pop_cnt), .o_push_cnt(push_cnt));

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = !i_clk;
	end

	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run

	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 5000) begin
			error_cnt++;
			complete_run();
		end
	end

	task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	task automatic a_xfer(input logic wr, input logic gate, input logic mb, input logic [35:0] d,
		output logic [35:0] q);
		@(posedge i_clk);
		i_port_a_chip_sel_n  <= 1'b0;
		i_port_a_direction   <= wr;
		i_port_a_xfer_gate   <= gate;
		i_port_a_mail_select <= mb;
		i_a_data             <= d;
		@(negedge i_clk);
		q = o_a_data;
		chk("a oe", 36'(!wr), 36'(o_a_data_oe));
		@(posedge i_clk);
		i_port_a_chip_sel_n <= 1'b1;
		i_port_a_xfer_gate  <= 1'b0;
	endtask : a_xfer

	task automatic b_xfer(input logic wr, input logic gate, input logic mb, input logic [35:0] d,
		output logic [35:0] q);
		@(posedge i_clk);
		i_port_b_chip_sel_n  <= 1'b0;
		i_port_b_direction   <= !wr;
		i_port_b_xfer_gate   <= gate;
		i_port_b_mail_select <= mb;
		i_b_data             <= d;
		@(negedge i_clk);
		q = o_b_data;
		chk("b oe", 36'(!wr), 36'(o_b_data_oe));
		@(posedge i_clk);
		i_port_b_chip_sel_n <= 1'b1;
		i_port_b_xfer_gate  <= 1'b0;
	endtask : b_xfer

	function automatic logic [35:0] lanes(input int n);
		lanes = (n == 1) ? 36'hF_FFFF_FFFF : ((n == 2) ? 36'h0_0003_FFFF : 36'h0_0000_01FF);
	endfunction : lanes

	// Piece i in transfer order of a long word split into n pieces
	function automatic logic [35:0] piece(input logic [35:0] w, input int n, input int i, input logic be);
		int s;
		s = (36 / n) * (be ? n - 1 - i : i);
		piece = (w >> s) & lanes(n);
	endfunction : piece

	function automatic logic [35:0] word_k(input int k);
		word_k = 36'h1_2345_6789 + 36'(k) * 36'h1_1111_1111;
	endfunction : word_k

	initial begin
		int          c, wi, n, i, pops, pushes;
		logic        be;
		logic [35:0] m, pat, w, q;
		{i_nrst, i_port_a_xfer_gate, i_port_b_xfer_gate, stall} = 4'h0;
		{i_first_full_reset_n, i_second_full_reset_n, i_port_a_chip_sel_n, i_port_b_chip_sel_n} = 4'hF;
		{i_width_match_select, i_narrow_width_select, i_endian_order_select} = 3'h1;
		{i_port_a_direction, i_port_b_direction, i_port_a_mail_select, i_port_b_mail_select} = 4'h0;
		i_a_data = 36'h0_0000_0000;
		i_b_data = 36'h0_0000_0000;
		pops = 0;
		pushes = 0;
		repeat (5) @(posedge i_clk);
		i_nrst <= 1'b1;
		repeat (2) @(posedge i_clk);
		#1 chk("reset flags", 36'h3, 36'({o_mail_to_b_vacant, o_mail_to_a_vacant}));
		for (c = 0; c < 6; c++) begin
			wi = c / 2;
			be = c[0];
			n  = (wi == 0) ? 1 : wi * 2;
			m  = lanes(n);
			@(posedge i_clk);
			i_first_full_reset_n  <= 1'b0;
			i_second_full_reset_n <= 1'b0;
			i_width_match_select  <= (wi != 0);
			i_narrow_width_select <= (wi == 2);
			i_endian_order_select <= be;
			repeat (2) @(posedge i_clk);
			i_first_full_reset_n  <= 1'b1;
			i_second_full_reset_n <= 1'b1;
			@(posedge i_clk);
			i_endian_order_select <= !be;
			repeat (2) @(posedge i_clk);
			#1 chk("width", 36'(wi), 36'(o_port_b_width));
			chk("order", 36'(be), 36'(o_big_endian));
			pat = 36'hA_5A5A_5A5A ^ 36'(c);
			a_xfer(1'b1, 1'b1, 1'b1, pat, q);
			#1 chk("a2b flag", 36'h0, 36'(o_mail_to_b_vacant));
			a_xfer(1'b1, 1'b1, 1'b1, ~pat, q);
			b_xfer(1'b0, 1'b1, 1'b1, 36'h0, q);
			chk("a2b mail", pat & m, q);
			#1 chk("a2b flag", 36'h1, 36'(o_mail_to_b_vacant));
			b_xfer(1'b0, 1'b1, 1'b1, 36'h0, q);
			chk("a2b reread", pat & m, q);
			b_xfer(1'b1, 1'b1, 1'b1, ~pat, q);
			#1 chk("b2a flag", 36'h0, 36'(o_mail_to_a_vacant));
			a_xfer(1'b0, 1'b1, 1'b1, 36'h0, q);
			chk("b2a mail", ~pat & m, q);
			#1 chk("b2a flag", 36'h1, 36'(o_mail_to_a_vacant));
			w = word_k(pops);
			pops++;
			for (i = 0; i < n; i++) begin
				b_xfer(1'b0, 1'b1, 1'b0, 36'h0, q);
				b_xfer(1'b0, 1'b0, 1'b0, 36'h0, q);
				chk("fifo1 piece", piece(w, n, i, be), q);
			end
			chk("pops", 36'(pops), 36'(pop_cnt));
			w = 36'h9_8765_4321 ^ 36'(c << 8);
			for (i = 0; i < n; i++)
				b_xfer(1'b1, 1'b1, 1'b0, piece(w, n, i, be) | ~m, q);
			pushes++;
			@(posedge i_clk);
			#1 chk("push count", 36'(pushes), 36'(push_cnt));
			chk("fifo2 word", w, i_fifo2_out_word);
			a_xfer(1'b0, 1'b0, 1'b0, 36'h0, q);
			chk("port a fifo", w, q);
			$display("test %0d done", c);
		end
		@(posedge i_clk);
		stall <= 1'b1;
		b_xfer(1'b0, 1'b1, 1'b0, 36'h0, q);
		#1 chk("stalled pop", 36'(pops), 36'(pop_cnt));
		b_xfer(1'b1, 1'b1, 1'b0, 36'h0_0000_01FF, q);
		stall <= 1'b0;
		for (i = 0; i < 4; i++)
			b_xfer(1'b1, 1'b1, 1'b0, piece(w, 4, i, 1'b1), q);
		pushes++;
		@(posedge i_clk);
		#1 chk("room refused word", w, i_fifo2_out_word);
		chk("room refused pushes", 36'(pushes), 36'(push_cnt));
		$display("test stall done");
		complete_run();
	end
endmodule : mbm_top_bench
